//--- core/sctw_pkg.sv
// package for the secure chip two-wire slave port
package sctw_pkg;
   // bus address width and direction encoding
   localparam int ADDR_W = 7;
   localparam logic DIR_WRITE = 1'h0;
   localparam logic DIR_READ = 1'h1;
   // sub-address field positions
   localparam int SUB_ENC_POS = 7;
   localparam int SUB_FB_POS = 4;
   localparam int SUB_HASH_POS = 3;
   localparam int SUB_LOOP_MSB = 2;
   // bypass test pattern
   localparam logic [7:0] BYPASS_XOR = 8'h01;
   // bytes per encryption block
   localparam int BLOCK_BYTES = 16;
   localparam logic [3:0] LAST_IDX = 4'hF;
   // bit counter end, ninth clock is the acknowledge slot
   localparam logic [3:0] ACK_BIT = 4'h8;
   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int SLEEP_MS = 2000;
   localparam longint SLEEP_CYCLES_L = longint'(CLK_HZ) / 1000 * SLEEP_MS;
   // configuration decoded from the sub-address byte
   typedef struct packed {
      logic encrypt_enable_bit;
      logic feedback_enable_bit;
      logic hash_enable_bit;
      logic [2:0] loop_count_field;
   } sctw_cfg_t;
   // one received byte with its place in the frame
   typedef struct packed {
      logic [7:0] data;
      logic [3:0] index;
   } sctw_byte_t;
endpackage

//--- core/sctw_slave.sv
// two-wire slave port: address match, sub-address config, write/read bytes, sleep
//
// Notes on behaviour
// - The port is only a target: it never drives the clock line and never starts a transfer.
// - Each transfer opens with a start then a 7-bit address and one direction bit.
// - A direction bit of 0 means the host writes bytes to the port.
// - A direction bit of 1 means the port drives data bytes back to the host.
// - A write is start, address+write, ack, sub-address, ack, acked data bytes, stop.
// - A read is address+write, sub-address, repeated start, address+read, then data until stop.
// - The port follows traffic up to 400 kbit/s, oversampled by the 10 MHz core clock.
// - Only the port's own address is answered; other targets' transfers are ignored.
// - Sub-address bit 7 enables encryption, 4 feedback, 3 hash, 6:5 reserved, 2:0 loop count.
// - After over 2 s of both lines high and idle the port requests sleep, and wakes on any low line.
// - In encryption use a write carries 16 seed bytes and a read returns 16 result bytes.
// - In bypass mode each written byte is returned xor 0x01.
`timescale 1ns/1ps
module sctw_slave
   import sctw_pkg::*;
#(
   parameter logic [6:0] OWN_ADDR = 7'h2A, // arbitrary default target address
   parameter longint SLEEP_CYCLES = SLEEP_CYCLES_L
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // two-wire pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // configuration toward the encryption core
   output sctw_pkg::sctw_cfg_t cfg_out,
   output logic cfg_valid_out,
   // written bytes toward the core
   output sctw_pkg::sctw_byte_t wr_byte_out,
   output logic wr_valid_out,
   // result bytes from the core, indexed by read position
   output logic [3:0] rd_index_out,
   input wire logic [7:0] rd_data_in,
   // status
   output logic busy_out,
   output logic sleep_out
);
   import sctw_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_RDATA, ST_IGNORE} sctw_state_t;

   logic [1:0] scl_sync_reg, sda_sync_reg;
   logic scl_d_reg, sda_d_reg;
   sctw_state_t state_reg;
   logic [3:0] bit_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [3:0] idx_reg;
   logic ack_phase_reg;
   logic drive_low_reg;
   logic host_nack_reg;
   logic [7:0] bypass_reg [BLOCK_BYTES];
   logic [31:0] idle_cnt_reg;
   sctw_cfg_t cfg_reg;
   logic cfg_valid_reg, wr_valid_reg, sleep_reg;
   logic busy_reg;
   sctw_byte_t wr_byte_reg;

   // synchronise both pins; stage 0 only feeds stage 1
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg <= 1'h1;
         sda_d_reg <= 1'h1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_d_reg <= scl_sync_reg[1];
         sda_d_reg <= sda_sync_reg[1];
      end
   end

   // edge and condition decode; 10 MHz gives 4+ samples per fast-mode half bit
   wire scl_s = scl_sync_reg[1];
   wire sda_s = sda_sync_reg[1];
   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire start_det = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
   wire stop_det = scl_s & scl_d_reg & sda_s & ~sda_d_reg;
   wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
   wire byte_done = scl_rise & (bit_reg == 4'h7) & ~ack_phase_reg;
   wire addr_hit = (rx_byte[7:1] == OWN_ADDR);
   wire is_read = (rx_byte[0] == DIR_READ);
   wire bypass_mode = ~cfg_reg.encrypt_enable_bit;
   wire [7:0] rd_byte = bypass_mode ? (bypass_reg[idx_reg] ^ BYPASS_XOR) : rd_data_in;
   wire lines_idle = scl_s & sda_s & (state_reg == ST_IDLE);

   // protocol state machine
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
         bit_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         idx_reg <= 4'h0;
         ack_phase_reg <= 1'h0;
         drive_low_reg <= 1'h0;
         host_nack_reg <= 1'h0;
         cfg_reg <= '0;
         cfg_valid_reg <= 1'h0;
         wr_valid_reg <= 1'h0;
         wr_byte_reg <= '0;
      end else begin
         cfg_valid_reg <= 1'h0;
         wr_valid_reg <= 1'h0;
         if (start_det) begin
            // repeated start keeps the sub-address already taken
            state_reg <= ST_ADDR;
            bit_reg <= 4'h0;
            ack_phase_reg <= 1'h0;
            drive_low_reg <= 1'h0;
            host_nack_reg <= 1'h0;
         end else if (stop_det) begin
            state_reg <= ST_IDLE;
            drive_low_reg <= 1'h0;
         end else if (state_reg != ST_IDLE && state_reg != ST_IGNORE) begin
            if (scl_rise && !ack_phase_reg) begin
               shift_reg <= rx_byte;
               bit_reg <= bit_reg + 4'h1;
            end
            if (scl_rise && ack_phase_reg && state_reg == ST_RDATA) begin
               host_nack_reg <= sda_s;
            end
            if (byte_done) begin
               case (state_reg)
                  ST_ADDR: begin
                     if (!addr_hit) begin
                        state_reg <= ST_IGNORE;
                     end
                  end
                  ST_SUB: begin
                     // bits 6:5 are reserved and dropped
                     cfg_reg.encrypt_enable_bit <= rx_byte[SUB_ENC_POS];
                     cfg_reg.feedback_enable_bit <= rx_byte[SUB_FB_POS];
                     cfg_reg.hash_enable_bit <= rx_byte[SUB_HASH_POS];
                     cfg_reg.loop_count_field <= rx_byte[SUB_LOOP_MSB:0];
                     cfg_valid_reg <= 1'h1;
                     idx_reg <= 4'h0;
                  end
                  ST_WDATA: begin
                     wr_byte_reg <= '{data: rx_byte, index: idx_reg};
                     wr_valid_reg <= 1'h1;
                  end
                  ST_RDATA: begin
                     // step early so the core's combinational answer settles before the ack slot ends
                     idx_reg <= idx_reg + 4'h1;
                  end
                  default: ;
               endcase
            end
            // falling edge after the eighth bit opens the ack slot
            if (scl_fall) begin
               if (!ack_phase_reg && bit_reg == ACK_BIT) begin
                  ack_phase_reg <= 1'h1;
                  bit_reg <= 4'h0;
                  drive_low_reg <= (state_reg != ST_RDATA);
               end else if (ack_phase_reg) begin
                  ack_phase_reg <= 1'h0;
                  drive_low_reg <= 1'h0;
                  case (state_reg)
                     ST_ADDR: begin
                        state_reg <= (shift_reg[0] == DIR_WRITE) ? ST_SUB : ST_RDATA;
                        if (shift_reg[0] == DIR_READ) begin
                           tx_reg <= rd_byte;
                           drive_low_reg <= ~rd_byte[7];
                        end
                     end
                     ST_SUB: state_reg <= ST_WDATA;
                     ST_WDATA: idx_reg <= idx_reg + 4'h1;
                     ST_RDATA: begin
                        if (host_nack_reg) begin
                           state_reg <= ST_IGNORE;
                        end else begin
                           // index already moved on at the last data bit
                           tx_reg <= rd_byte;
                           drive_low_reg <= ~rd_byte[7];
                        end
                     end
                     default: ;
                  endcase
               end else if (state_reg == ST_RDATA) begin
                  tx_reg <= {tx_reg[6:0], 1'h1};
                  drive_low_reg <= ~tx_reg[6];
               end
            end
         end
      end
   end

   // bypass store, one slot per seed byte
   genvar gi;
   generate
      for (gi = 0; gi < BLOCK_BYTES; gi++) begin : g_byp
         always_ff @(posedge core_clk_in) begin
            if (rst_in) begin
               bypass_reg[gi] <= 8'h00;
            end else if (byte_done && state_reg == ST_WDATA && idx_reg == 4'(gi)) begin
               bypass_reg[gi] <= rx_byte;
            end
         end
      end
   endgenerate

   // sleep timer; any low line wakes at once
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         idle_cnt_reg <= 32'h0;
         sleep_reg <= 1'h0;
      end else if (!lines_idle) begin
         idle_cnt_reg <= 32'h0;
         sleep_reg <= 1'h0;
      end else if (idle_cnt_reg >= 32'(SLEEP_CYCLES)) begin
         sleep_reg <= 1'h1;
      end else begin
         idle_cnt_reg <= idle_cnt_reg + 32'h1;
      end
   end

   // busy flag registered so the port output comes from a flop
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         busy_reg <= 1'h0;
      end else begin
         busy_reg <= (state_reg != ST_IDLE);
      end
   end

   // outputs; data line is open drain, only ever pulled low, clock never driven
   assign sda_out = 1'h0;
   assign sda_oe_out = drive_low_reg;
   assign cfg_out = cfg_reg;
   assign cfg_valid_out = cfg_valid_reg;
   assign wr_byte_out = wr_byte_reg;
   assign wr_valid_out = wr_valid_reg;
   assign rd_index_out = idx_reg;
   assign busy_out = busy_reg;
   assign sleep_out = sleep_reg;

   // assertions
   a_ack_after_byte: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (byte_done && state_reg == ST_SUB) |-> ##[1:200] sda_oe_out)
      else $error("sub-address not acknowledged");
   a_foreign_ignored: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (byte_done && state_reg == ST_ADDR && !addr_hit) |=> (state_reg == ST_IGNORE))
      else $error("foreign address not ignored");
   a_cfg_decode: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (byte_done && state_reg == ST_SUB) |=> (cfg_out.encrypt_enable_bit == $past(rx_byte[7]) && cfg_valid_out))
      else $error("sub-address decode wrong");
   a_idle_quiet: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (state_reg == ST_IDLE) |-> !drive_low_reg)
      else $error("data driven while idle");
   a_wake_fast: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (sleep_out && !scl_s) |=> !sleep_out)
      else $error("no wake on low line");
   a_stop_idle: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (stop_det && !start_det) |=> (state_reg == ST_IDLE))
      else $error("stop not honoured");
   a_start_addr: assert property (@(posedge core_clk_in) disable iff (rst_in)
      start_det |=> (state_reg == ST_ADDR && bit_reg == 4'h0))
      else $error("start not honoured");
   a_write_store: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (byte_done && state_reg == ST_WDATA) |=> (wr_valid_out && wr_byte_out.data == $past(rx_byte)))
      else $error("write byte lost");
endmodule // sctw_slave

//--- bench/sctw_host_model.sv
// two-wire bus master model that drives the port's pins
`timescale 1ns/1ps
module sctw_host_model (
   // clock and pins
   input wire logic core_clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   // bus idle: clock high, data released to the pull-up
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   // a quarter of the 800 ns bus period; the bus clock stands still outside frames
   task automatic qtr();
      repeat (2) @(negedge core_clk_in);
   endtask
   // one bit slot; data changes mid-low, the line is sampled mid-high
   task automatic bit_slot(input logic b, output logic s);
      qtr();
      sda_oe_out = ~b;
      qtr();
      scl_out = 1'b1;
      qtr();
      s = sda_in;
      qtr();
      scl_out = 1'b0;
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic start();
      qtr();
      sda_oe_out = 1'b0;
      qtr();
      scl_out = 1'b1;
      qtr();
      sda_oe_out = 1'b1;
      qtr();
      scl_out = 1'b0;
   endtask
   // stop: data rises while the clock is high
   task automatic stop();
      qtr();
      sda_oe_out = 1'b1;
      qtr();
      scl_out = 1'b1;
      qtr();
      sda_oe_out = 1'b0;
      qtr();
   endtask
   // hold the clock line at a level outside frames, used to wake a sleeping port
   task automatic park(input logic lvl);
      scl_out = lvl;
   endtask
   // eight bits msb first, then the acknowledge slot
   task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
      for (int i = 7; i >= 0; i--) begin
         bit_slot(tx[i], rx[i]);
      end
      bit_slot(ack_tx, ack_rx);
   endtask
endmodule // sctw_host_model

//--- bench/tb_top.sv
// testbench for the two-wire slave port
`timescale 1ns/1ps
module tb_top;
   import sctw_pkg::*;
   localparam logic [6:0] MY_ADDR = 7'h2A; // arbitrary target address
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic scl, host_oe, sda_wire, sda_out, sda_oe_out, cfg_valid_out, wr_valid_out, busy_out, sleep_out;
   sctw_cfg_t cfg_out;
   sctw_cfg_t cfg_seen;
   sctw_byte_t wr_byte_out;
   logic [3:0] rd_index_out;
   logic [7:0] rd_data_in;
   logic [7:0] seen [16];
   int n_wr = 0;
   int mismatches = 0;
   int checks = 0;
   always #50 core_clk_in = ~core_clk_in;
   // open-drain wire with pull-up; result bytes follow the read index
   assign sda_wire = ~(host_oe | sda_oe_out);
   assign rd_data_in = {4'hC, rd_index_out};
   sctw_slave #(.OWN_ADDR(MY_ADDR), .SLEEP_CYCLES(50)) i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
      .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .cfg_out(cfg_out),
      .cfg_valid_out(cfg_valid_out), .wr_byte_out(wr_byte_out), .wr_valid_out(wr_valid_out),
      .rd_index_out(rd_index_out), .rd_data_in(rd_data_in), .busy_out(busy_out), .sleep_out(sleep_out));
   sctw_host_model i_host (.core_clk_in(core_clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_oe_out(host_oe));
   // capture pulsed outputs so they are judged after the byte ends
   always @(posedge core_clk_in) begin
      if (wr_valid_out === 1'b1) begin
         seen[wr_byte_out.index] <= wr_byte_out.data;
         n_wr <= n_wr + 1;
      end
      if (cfg_valid_out === 1'b1) begin
         cfg_seen <= cfg_out;
      end
   end
   task automatic check(input logic [11:0] seen_v, input logic [11:0] exp_v);
      checks++;
      if (seen_v !== exp_v) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask
   task automatic test_done();
      if (mismatches == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // bounded wait for the sleep request level
   task automatic wait_sleep(input logic lvl);
      int n;
      n = 0;
      while (sleep_out !== lvl && n < 200) begin
         @(negedge core_clk_in);
         n++;
      end
      if (sleep_out !== lvl) begin
         mismatches++;
         test_done();
      end
   endtask
   // the host keeps 1 ms of free bus after this task's stop
   task automatic idle();
      i_host.stop();
      repeat (10000) @(negedge core_clk_in);
   endtask
   // start, address with write, then the sub-address
   task automatic open_sub(input logic [7:0] sub, output logic a1, output logic a2);
      logic [7:0] rx;
      i_host.start();
      i_host.xfer({MY_ADDR, DIR_WRITE}, 1'b1, rx, a1);
      i_host.xfer(sub, 1'b1, rx, a2);
   endtask
   initial begin
      logic a1;
      logic a2;
      logic [7:0] rx;
      logic [7:0] wdat [16];
      repeat (4) @(negedge core_clk_in);
      rst_in = 1'b0;
      check({busy_out, sleep_out, sda_oe_out, 2'h0, sda_out, cfg_out}, 12'h000);
      repeat (3) @(negedge core_clk_in);
      // foreign target is left unanswered
      i_host.start();
      i_host.xfer({7'h2B, DIR_WRITE}, 1'b1, rx, a1);
      check(12'(a1), 12'h001);
      i_host.xfer(8'h55, 1'b1, rx, a2);
      check({a2, 11'(n_wr)}, 12'h800);
      idle();
      // write: sub-address with reserved bits set, then sixteen bytes
      open_sub(8'h7D, a1, a2);
      check({9'h0, busy_out, a1, a2}, 12'h004);
      check({6'h0, cfg_seen}, 12'h01D);
      for (int k = 0; k < 16; k++) begin
         wdat[k] = 8'(k * 37 + 5);
         i_host.xfer(wdat[k], 1'b1, rx, a1);
         check(12'(a1), 12'h000);
      end
      check(12'(n_wr), 12'h010);
      for (int k = 0; k < 16; k++) begin
         check({4'h0, seen[k]}, {4'h0, wdat[k]});
      end
      idle();
      check(12'(n_wr), 12'h010);
      // bypass read after a repeated start
      open_sub(8'h7D, a1, a2);
      i_host.start();
      i_host.xfer({MY_ADDR, DIR_READ}, 1'b1, rx, a1);
      check(12'(a1), 12'h000);
      for (int k = 0; k < 16; k++) begin
         i_host.xfer(8'hFF, k == 15, rx, a2);
         check({4'h0, rx}, {4'h0, wdat[k] ^ BYPASS_XOR});
      end
      repeat (6) @(negedge core_clk_in);
      check(12'(sda_oe_out), 12'h000);
      idle();
      // encryption read returns the core's result bytes
      open_sub(8'h85, a1, a2);
      check({6'h0, cfg_seen}, 12'h025);
      i_host.start();
      i_host.xfer({MY_ADDR, DIR_READ}, 1'b1, rx, a1);
      for (int k = 0; k < 16; k++) begin
         i_host.xfer(8'hFF, k == 15, rx, a2);
         check({4'h0, rx}, {4'h0, 4'hC, 4'(k)});
      end
      i_host.stop();
      // sleep only after the idle count, wake on a low clock line
      repeat (30) @(negedge core_clk_in);
      check(12'(sleep_out), 12'h000);
      wait_sleep(1'b1);
      check(12'(sleep_out), 12'h001);
      i_host.park(1'b0);
      wait_sleep(1'b0);
      check(12'(sleep_out), 12'h000);
      i_host.park(1'b1);
      test_done();
   end
endmodule // tb_top
